/* common/rbx_defines.svh */
// Constants for the return and bit-set execution block
`ifndef RBX_DEFINES_SVH
`define RBX_DEFINES_SVH

`define RBX_INSTR_W 10
`define RBX_PC_W 14
`define RBX_SP_W 3
`define RBX_STK_DEPTH 8
`define RBX_MP_W 10
`define RBX_NIB_W 4

`define RBX_OP_RET_SUB 10'h044
`define RBX_OP_RET_SKIP 10'h045
`define RBX_OP_RET_INT 10'h046
`define RBX_OP_CARRY_SET 10'h007
`define RBX_OP_BIT_SET 10'h05C
`define RBX_OP_BIT_MASK 10'h3FC

`define RBX_PC_RST 14'h0000
`define RBX_SP_RST 3'h7
`define RBX_INT_VEC 14'h0008

`define RBX_ADDR_W 12
`define RBX_REG_CTRL 12'h000
`define RBX_REG_STAT 12'h004
`define RBX_REG_CTX 12'h008
`define RBX_REG_PC 12'h00C
`define RBX_CTRL_EN_BIT 0
`define RBX_CTRL_RST 32'h0000_0001

`endif

/* common/rbx_pkg.sv */
// Types for the return and bit-set execution block
package rbx_pkg;
  typedef enum logic [1:0] {
    RBX_IDLE = 2'b01,
    RBX_RET2 = 2'b10
  } rbx_state_t;
endpackage

/* rtl/rbx_exec.sv */
// Return, interrupt-return, bit-set and carry-set execution unit
`include "rbx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Subroutine return 044: PC from stack at SP, then SP minus one.
// - Interrupt return 046: PC from stack, SP minus one, resume.
// - Interrupt return restores the pointer saved at entry.
// - Interrupt return restores carry, pending skip and no-op mode.
// - Interrupt return restores the load chaining status.
// - Interrupt return restores accumulator and second register.
// - Return-and-skip 045: return, then always skip next word.
// - Bit set 05C+j sets bit j, 0 to 3, of word at pointer.
module rbx_exec (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [`RBX_INSTR_W-1:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic int_entry_in,
  input wire logic call_in,
  input wire logic [`RBX_PC_W-1:0] call_tgt_in,
  input wire logic upd_in,
  input wire logic [`RBX_NIB_W-1:0] upd_a_in,
  input wire logic [`RBX_NIB_W-1:0] upd_b_in,
  input wire logic [`RBX_MP_W-1:0] upd_mp_in,
  input wire logic upd_carry_in,
  input wire logic upd_nop_in,
  input wire logic upd_chain_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RBX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy_out,
  output logic [`RBX_PC_W-1:0] pc_out,
  output logic [`RBX_SP_W-1:0] sp_out,
  output logic carry_flag_out,
  output logic skip_out,
  output logic nop_mode_out,
  output logic chain_out,
  output logic [`RBX_NIB_W-1:0] acc_out,
  output logic [`RBX_NIB_W-1:0] regb_out,
  output logic [`RBX_MP_W-1:0] memory_pointer_out,
  output logic mem_set_out,
  output logic [`RBX_MP_W-1:0] mem_addr_out,
  output logic [1:0] mem_bit_out
);

  function automatic logic op_is(input logic [`RBX_INSTR_W-1:0] op,
                                 input logic [`RBX_INSTR_W-1:0] code,
                                 input logic [`RBX_INSTR_W-1:0] mask);
    op_is = (op & mask) == code;
  endfunction

  localparam logic [`RBX_INSTR_W-1:0] FULL = 10'h3FF;
  localparam int SP_W = `RBX_SP_W;

  rbx_pkg::rbx_state_t state_r;
  rbx_pkg::rbx_state_t state_nxt;
  logic [`RBX_PC_W-1:0] pc_r;
  logic [`RBX_PC_W-1:0] pc_nxt;
  logic [`RBX_SP_W-1:0] sp_r;
  logic [`RBX_SP_W-1:0] sp_nxt;
  logic [`RBX_PC_W-1:0] return_stack_r [`RBX_STK_DEPTH];
  logic carry_r;
  logic carry_nxt;
  logic skip_r;
  logic skip_nxt;
  logic nop_r;
  logic nop_nxt;
  logic chain_r;
  logic chain_nxt;
  logic [`RBX_NIB_W-1:0] a_r;
  logic [`RBX_NIB_W-1:0] a_nxt;
  logic [`RBX_NIB_W-1:0] b_r;
  logic [`RBX_NIB_W-1:0] b_nxt;
  logic [`RBX_MP_W-1:0] mp_r;
  logic [`RBX_MP_W-1:0] mp_nxt;
  logic sv_carry_r;
  logic sv_skip_r;
  logic sv_nop_r;
  logic sv_chain_r;
  logic [`RBX_NIB_W-1:0] sv_a_r;
  logic [`RBX_NIB_W-1:0] sv_b_r;
  logic [`RBX_MP_W-1:0] sv_mp_r;
  logic busy_r;
  logic mem_set_r;
  logic [`RBX_MP_W-1:0] mem_addr_r;
  logic [1:0] mem_bit_r;
  logic [31:0] ctrl_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // Sequencing qualifiers
  wire idle = (state_r == rbx_pkg::RBX_IDLE);
  wire en = ctrl_r[`RBX_CTRL_EN_BIT];
  wire ent = int_entry_in & idle;
  wire cal = call_in & idle & ~int_entry_in;
  wire acc = instr_valid_in & idle & en & ~int_entry_in & ~call_in;
  // A pending skip swallows the next accepted word whatever it is
  wire skp = acc & skip_r;
  wire exe = acc & ~skip_r;
  wire is_ret_sub = op_is(instr_in, `RBX_OP_RET_SUB, FULL);
  wire is_ret_skip = op_is(instr_in, `RBX_OP_RET_SKIP, FULL);
  wire is_ret_int = op_is(instr_in, `RBX_OP_RET_INT, FULL);
  wire is_carry_set = op_is(instr_in, `RBX_OP_CARRY_SET, FULL);
  wire is_bit_set = op_is(instr_in, `RBX_OP_BIT_SET, `RBX_OP_BIT_MASK);
  wire do_ret_sub = exe & is_ret_sub;
  wire do_ret_skip = exe & is_ret_skip;
  wire do_ret_int = exe & is_ret_int;
  wire do_bit_set = exe & is_bit_set;
  wire do_carry_set = exe & is_carry_set;
  wire pop = do_ret_sub | do_ret_skip | do_ret_int;
  wire push = ent | cal;
  wire [`RBX_SP_W-1:0] sp_inc = sp_r + 3'h1;
  wire [`RBX_SP_W-1:0] sp_dec = sp_r - 3'h1;
  wire [`RBX_PC_W-1:0] top = return_stack_r[sp_r];

  assign pc_nxt = ent ? `RBX_INT_VEC :
                  cal ? call_tgt_in :
                  pop ? top :
                  acc ? pc_r + 14'h0001 : pc_r;
  assign sp_nxt = push ? sp_inc : pop ? sp_dec : sp_r;
  // Subroutine returns hold the sequencer one more cycle
  assign state_nxt = (do_ret_sub | do_ret_skip) ?
                     rbx_pkg::RBX_RET2 : rbx_pkg::RBX_IDLE;
  assign carry_nxt = do_ret_int ? sv_carry_r :
                     do_carry_set ? 1'b1 :
                     upd_in ? upd_carry_in : carry_r;
  // Set wins over the clear that a swallowed word causes
  assign skip_nxt = do_ret_int ? sv_skip_r :
                    do_ret_skip ? 1'b1 :
                    skp ? 1'b0 : skip_r;
  assign nop_nxt = do_ret_int ? sv_nop_r :
                   upd_in ? upd_nop_in : nop_r;
  assign chain_nxt = do_ret_int ? sv_chain_r :
                     upd_in ? upd_chain_in : chain_r;
  // Restore beats a same-cycle update from the rest of the core
  assign a_nxt = do_ret_int ? sv_a_r : upd_in ? upd_a_in : a_r;
  assign b_nxt = do_ret_int ? sv_b_r : upd_in ? upd_b_in : b_r;
  assign mp_nxt = do_ret_int ? sv_mp_r :
                  upd_in ? upd_mp_in : mp_r;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= rbx_pkg::RBX_IDLE;
      pc_r <= `RBX_PC_RST;
      sp_r <= `RBX_SP_RST;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      busy_r <= (state_nxt == rbx_pkg::RBX_RET2);
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      carry_r <= 1'b0;
      skip_r <= 1'b0;
      nop_r <= 1'b0;
      chain_r <= 1'b0;
      a_r <= 4'h0;
      b_r <= 4'h0;
      mp_r <= 10'h000;
    end else begin
      carry_r <= carry_nxt;
      skip_r <= skip_nxt;
      nop_r <= nop_nxt;
      chain_r <= chain_nxt;
      a_r <= a_nxt;
      b_r <= b_nxt;
      mp_r <= mp_nxt;
    end
  end

  // Single save set: a nested entry overwrites the outer context
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sv_carry_r <= 1'b0;
      sv_skip_r <= 1'b0;
      sv_nop_r <= 1'b0;
      sv_chain_r <= 1'b0;
      sv_a_r <= 4'h0;
      sv_b_r <= 4'h0;
      sv_mp_r <= 10'h000;
    end else if (ent) begin
      sv_carry_r <= carry_r;
      sv_skip_r <= skip_r;
      sv_nop_r <= nop_r;
      sv_chain_r <= chain_r;
      sv_a_r <= a_r;
      sv_b_r <= b_r;
      sv_mp_r <= mp_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `RBX_STK_DEPTH; gi++) begin : g_stk
      always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          return_stack_r[gi] <= `RBX_PC_RST;
        end else if (push && sp_inc == SP_W'(gi)) begin
          return_stack_r[gi] <= pc_r;
        end
      end
    end
  endgenerate

  // Memory bit-set request, one pulse per executed word
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_set_r <= 1'b0;
      mem_addr_r <= 10'h000;
      mem_bit_r <= 2'h0;
    end else begin
      mem_set_r <= do_bit_set;
      if (do_bit_set) begin
        mem_addr_r <= mp_r;
        mem_bit_r <= instr_in[1:0];
      end
    end
  end

  // APB slave, one wait-free access phase per transfer
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready_r & pwrite;
  wire hit_ctrl = (paddr == `RBX_REG_CTRL);
  wire hit_stat = (paddr == `RBX_REG_STAT);
  wire hit_ctx = (paddr == `RBX_REG_CTX);
  wire hit_pc = (paddr == `RBX_REG_PC);
  wire mapped = hit_ctrl | hit_stat | hit_ctx | hit_pc;
  wire [31:0] stat_w = {8'h00, busy_r, nop_r, skip_r, carry_r, 1'b0,
                        sp_r, 2'h0, pc_r};
  wire [31:0] ctx_w = {13'h0000, chain_r, b_r, a_r, mp_r};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_stat ? stat_w :
                       hit_ctx ? ctx_w :
                       hit_pc ? {18'h00000, pc_r} : 32'h0000_0000;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      ctrl_r <= `RBX_CTRL_RST;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_go && hit_ctrl) begin
        ctrl_r <= {31'h0000_0000, pwdata[`RBX_CTRL_EN_BIT]};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign busy_out = busy_r;
  assign pc_out = pc_r;
  assign sp_out = sp_r;
  assign carry_flag_out = carry_r;
  assign skip_out = skip_r;
  assign nop_mode_out = nop_r;
  assign chain_out = chain_r;
  assign acc_out = a_r;
  assign regb_out = b_r;
  assign memory_pointer_out = mp_r;
  assign mem_set_out = mem_set_r;
  assign mem_addr_out = mem_addr_r;
  assign mem_bit_out = mem_bit_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_ret_sub_pop: assert property (
    do_ret_sub |=> pc_r == $past(top) && sp_r == $past(sp_dec))
    else $error("subroutine return did not pop the stack");
  a_ret_int_pop: assert property (
    do_ret_int |=> pc_r == $past(top) && sp_r == $past(sp_r) - 3'h1)
    else $error("interrupt return did not pop the stack");
  a_entry_save: assert property (
    ent |=> sv_mp_r == $past(mp_r) && sv_skip_r == $past(skip_r)
            && sv_carry_r == $past(carry_r) && sv_a_r == $past(a_r))
    else $error("context not saved on interrupt entry");
  a_ret_int_pointer: assert property (
    do_ret_int |=> mp_r == $past(sv_mp_r))
    else $error("pointer not restored on interrupt return");
  a_ret_int_flags: assert property (
    do_ret_int |=> carry_r == $past(sv_carry_r)
                   && skip_r == $past(sv_skip_r)
                   && nop_r == $past(sv_nop_r))
    else $error("flags not restored on interrupt return");
  a_ret_int_chain: assert property (
    do_ret_int |=> chain_r == $past(sv_chain_r))
    else $error("chain status not restored");
  a_ret_int_regs: assert property (
    do_ret_int |=> a_r == $past(sv_a_r) && b_r == $past(sv_b_r))
    else $error("working registers not restored");
  a_skip_return: assert property (
    do_ret_skip |=> skip_r && busy_r ##1 (instr_valid_in && en
                    && !int_entry_in && !call_in) |=> !skip_r)
    else $error("return-and-skip did not skip");
  a_bit_request: assert property (
    do_bit_set |=> mem_set_r && mem_bit_r == $past(instr_in[1:0])
                   && mem_addr_r == $past(mp_r))
    else $error("bit set request wrong");
  a_carry_set: assert property (
    do_carry_set |=> carry_r && skip_r == $past(skip_r) && !busy_r)
    else $error("carry set wrong");
  a_ret_cycles: assert property (
    (do_ret_sub | do_ret_skip) |=> busy_r && !idle ##1 !busy_r && idle)
    else $error("subroutine return not two cycles");

endmodule

`default_nettype wire

/* testbench/rbx_testbench.sv */
// Self-checking bench for the return and bit-set execution unit
`include "rbx_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_in, sys_rst_in, instr_valid_in, int_entry_in, call_in, upd_in;
  logic [9:0] instr_in, upd_mp_in, memory_pointer_out, mem_addr_out;
  logic [13:0] call_tgt_in, pc_out, mpc;
  logic [3:0] upd_a_in, upd_b_in, acc_out, regb_out;
  logic upd_carry_in, upd_nop_in, upd_chain_in, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, busy_out, carry_flag_out, skip_out, nop_mode_out;
  logic chain_out, mem_set_out;
  logic [2:0] sp_out, msp;
  logic [1:0] mem_bit_out;
  // Model context: a, b, pointer, carry, no-op mode, chaining, skip
  logic [21:0] m, s;
  int stk[8];
  int err_count, n_tests;
  int cyc = 0;

  rbx_exec rbx_exec_i (.sys_clk_in, .sys_rst_in, .instr_in, .instr_valid_in,
    .int_entry_in, .call_in, .call_tgt_in, .upd_in, .upd_a_in, .upd_b_in,
    .upd_mp_in, .upd_carry_in, .upd_nop_in, .upd_chain_in, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busy_out, .pc_out,
    .sp_out, .carry_flag_out, .skip_out, .nop_mode_out, .chain_out, .acc_out,
    .regb_out, .memory_pointer_out, .mem_set_out, .mem_addr_out,
    .mem_bit_out);

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short at cycle 3000, far above the roughly 70 cycles the run needs
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  task chk(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task st();
    chk({pc_out, sp_out}, {mpc, msp});
    chk({acc_out, regb_out, memory_pointer_out, carry_flag_out, nop_mode_out,
      chain_out, skip_out}, m);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready !== 1'b1) @(posedge sys_clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Offers i; nx/nv are what is offered in the cycle after it is taken
  task op(input logic [9:0] i, input logic [9:0] nx, input logic nv);
    logic bs;
    bs = !m[0] && ((i & `RBX_OP_BIT_MASK) == `RBX_OP_BIT_SET);
    @(posedge sys_clk_in);
    instr_in <= i;
    instr_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    instr_in <= nx;
    instr_valid_in <= nv;
    if (m[0]) begin
      m[0] = 1'b0;
      mpc = mpc + 14'h1;
    end else if (i == `RBX_OP_RET_SUB || i == `RBX_OP_RET_SKIP) begin
      mpc = 14'(stk[msp]);
      msp = msp - 3'h1;
      m[0] = (i == `RBX_OP_RET_SKIP);
    end else if (i == `RBX_OP_RET_INT) begin
      mpc = 14'(stk[msp]);
      msp = msp - 3'h1;
      m = s;
    end else begin
      mpc = mpc + 14'h1;
      m[3] = m[3] | (i == `RBX_OP_CARRY_SET);
    end
    #1;
    chk(mem_set_out, bs);
    if (bs) chk({mem_bit_out, mem_addr_out}, {i[1:0], m[13:4]});
  endtask

  task upd();
    @(posedge sys_clk_in);
    {upd_a_in, upd_b_in, upd_mp_in, upd_carry_in, upd_nop_in,
      upd_chain_in} <= 21'($urandom);
    upd_in <= 1'b1;
    @(posedge sys_clk_in);
    upd_in <= 1'b0;
    m[21:1] = {upd_a_in, upd_b_in, upd_mp_in, upd_carry_in, upd_nop_in,
      upd_chain_in};
    #1;
  endtask

  // Interrupt entry (ie=1) or call to t: pushes the current pc
  task push(input logic ie, input logic [13:0] t);
    @(posedge sys_clk_in);
    int_entry_in <= ie;
    call_in <= !ie;
    call_tgt_in <= t;
    @(posedge sys_clk_in);
    int_entry_in <= 1'b0;
    call_in <= 1'b0;
    msp = msp + 3'h1;
    stk[msp] = int'(mpc);
    mpc = ie ? `RBX_INT_VEC : t;
    if (ie) s = m;
    #1;
    st();
  endtask

  initial begin
    {instr_in, instr_valid_in, int_entry_in, call_in, call_tgt_in} = '0;
    {upd_in, upd_a_in, upd_b_in, upd_mp_in, upd_carry_in} = '0;
    {upd_nop_in, upd_chain_in, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    n_tests = 0;
    mpc = `RBX_PC_RST;
    msp = `RBX_SP_RST;
    m = '0;
    s = '0;
    sys_rst_in = 1'b1;
    void'($urandom(32'h935A));
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    st();
    apb(1'b0, `RBX_REG_CTRL, 32'h0);
    chk({er, rd}, {1'b0, `RBX_CTRL_RST});
    apb(1'b0, `RBX_REG_STAT, 32'h0);
    chk({er, rd}, 33'h0_0007_0000);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk({er, rd}, 33'h1_0000_0000);
    upd();
    push(1'b0, 14'($urandom));
    push(1'b0, 14'($urandom));
    op(`RBX_OP_RET_SUB, `RBX_OP_CARRY_SET, 1'b1);
    st();
    chk(busy_out, 1'b1);
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    #1;
    chk(busy_out, 1'b0);
    st();
    // Skip pending when the interrupt is taken must come back after it
    push(1'b0, 14'($urandom));
    op(`RBX_OP_RET_SKIP, 10'h0, 1'b0);
    st();
    push(1'b1, 14'h0);
    upd();
    op(`RBX_OP_CARRY_SET, 10'h0, 1'b0);
    st();
    op(`RBX_OP_CARRY_SET, 10'h0, 1'b0);
    st();
    op(`RBX_OP_RET_INT, 10'h0, 1'b0);
    st();
    chk(busy_out, 1'b0);
    op(`RBX_OP_BIT_SET, 10'h0, 1'b0);
    st();
    upd();
    for (int j = 0; j < 4; j++) begin
      op(`RBX_OP_BIT_SET + 10'(j), 10'h0, 1'b0);
      st();
    end
    // Status, context and pc registers mirror the model state
    apb(1'b0, `RBX_REG_STAT, 32'h0);
    chk({er, rd}, {10'h000, m[2], m[0], m[3], 1'b0, msp, 2'h0, mpc});
    apb(1'b0, `RBX_REG_CTX, 32'h0);
    chk({er, rd}, {14'h0000, m[1], m[17:14], m[21:18], m[13:4]});
    apb(1'b0, `RBX_REG_PC, 32'h0);
    chk({er, rd}, {19'h00000, mpc});
    // Disabled core ignores offered words
    apb(1'b1, `RBX_REG_CTRL, 32'h0);
    apb(1'b0, `RBX_REG_CTRL, 32'h0);
    chk({er, rd}, 33'h0);
    @(posedge sys_clk_in);
    instr_in <= `RBX_OP_CARRY_SET;
    instr_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    #1;
    st();
    apb(1'b1, `RBX_REG_CTRL, 32'h1);
    op(`RBX_OP_CARRY_SET, 10'h0, 1'b0);
    st();
    tally_and_finish();
  end
endmodule
`default_nettype wire
